// ===== include/host_timer_params.svh
// Offsets, field positions, reset values and timing counts of the host timer block
`ifndef HOST_TIMER_PARAMS_SVH
`define HOST_TIMER_PARAMS_SVH

`define TIMER_CONFIG_OFS 8'h8C
`define TIMER_COUNT_OFS 8'h90
`define FREE_CYCLE_COUNTER_OFS 8'h9C

// Enable sits at bit 29 of the word, bit 13 of the upper half-word
`define TIMER_RUN_BIT 29
`define TIMER_RUN_HALF_BIT 13
`define PRELOAD_RESET 16'hFFFF
`define COUNT_RESET 16'hFFFF
`define FREE_RESET 32'h0000_0000

`define CLK_PERIOD_NS 10
`define FREE_TICK_NS 40
`define FREE_TICK_CYCLES (`FREE_TICK_NS / `CLK_PERIOD_NS)
`define TIMER_TICK_NS 1000
`define TIMER_TICK_CYCLES (`TIMER_TICK_NS / `CLK_PERIOD_NS)
`define FREE_CLEAR_NS 160
`define FREE_CLEAR_CYCLES ((`FREE_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== include/host_timer_pkg.sv
// Types shared by the host timer block
package host_timer_pkg;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:1] addr;
    logic [15:0] data;
  } host_req_t;

  typedef enum logic [0:0] {
    TIMER_HALTED,
    TIMER_RUNNING
  } timer_state_t;

endpackage : host_timer_pkg

// ===== hdl/tick_divider.sv
// One-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  localparam int CW = $clog2(DIV) + 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] phase;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (phase == LAST);
      phase <= (phase == LAST) ? '0 : phase + CW'(1);
    end
  end

endmodule : tick_divider

// ===== hdl/timer_core.sv
// Down counter with reload and expiry pulse for the general purpose timer
`timescale 1ns/1ps
`include "host_timer_params.svh"
module timer_core
  import host_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [15:0] preload,
  output logic [15:0] count,
  output logic expire
);

  timer_state_t state;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= TIMER_HALTED;
    else
    begin
      case (state)
        TIMER_HALTED: if (run) state <= TIMER_RUNNING;
        TIMER_RUNNING: if (!run) state <= TIMER_HALTED;
        default: state <= TIMER_HALTED;
      endcase
    end
  end

  // Preload is sampled only at start and at reload, so writes mid-count wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= `COUNT_RESET;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      case (state)
        TIMER_HALTED:
          if (run)
            count <= preload;
        TIMER_RUNNING:
          if (run && tick)
          begin
            if (count == 16'h0000)
            begin
              count <= preload;
              expire <= 1'b1;
            end
            else
              count <= count - 16'h0001;
          end
        default: count <= `COUNT_RESET;
      endcase
    end
  end

endmodule : timer_core

// ===== hdl/host_timer_and_cycle_counter.sv
// Host timer and free-running cycle counter behind a 16-bit SRAM-like bus
// Notes on behaviour
// - Writing one to bit 29 runs the timer; clearing it halts it.
// - When the run bit falls, preload is forced back to FFFFh.
// - Timer starts from the writable preload in bits 15-0, reset FFFFh.
// - Read-only count register bits 15-0 show present timer value, FFFFh after reset.
// - Timer raises host interrupt events repeatedly at the configured interval.
// - Read-only 32-bit counter starts at zero, adds one every 25MHz cycle.
// - At all ones the counter wraps to zero and keeps counting.
// - First half-word read captures all 32 bits; second half comes from capture.
// - Counter may take up to 160ns to clear after reset.
// - No power state stops the free-running counter.
`timescale 1ns/1ps
`include "host_timer_params.svh"
module host_timer_and_cycle_counter
  import host_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:1] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic timer_irq_event
);

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  host_req_t req;
  logic rd_q;
  logic wr_q;
  logic rd_start;
  logic wr_start;
  logic [7:0] byte_addr;
  logic hit_cfg;
  logic hit_cnt;
  logic hit_free;
  logic upper_half;

  assign req = '{sel: !host_cs_n, rd: !host_rd_n, wr: !host_wr_n,
                 addr: host_addr, data: host_data_in};
  assign rd_start = req.sel && req.rd && !rd_q;
  assign wr_start = req.sel && req.wr && !wr_q;
  assign byte_addr = {req.addr, 1'b0};
  assign upper_half = byte_addr[1];
  assign hit_cfg = (byte_addr[7:2] == 6'(`TIMER_CONFIG_OFS >> 2));
  assign hit_cnt = (byte_addr[7:2] == 6'(`TIMER_COUNT_OFS >> 2));
  assign hit_free = (byte_addr[7:2] == 6'(`FREE_CYCLE_COUNTER_OFS >> 2));

  // Strobes act once, on the first cycle of each access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= req.sel && req.rd;
      wr_q <= req.sel && req.wr;
    end
  end

  logic run_en;
  logic [15:0] timer_preload_value;
  logic [15:0] timer_current_count;
  logic timer_expire;
  logic timer_tick;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_en <= 1'b0;
    else if (wr_start && hit_cfg && upper_half)
      run_en <= req.data[`TIMER_RUN_HALF_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_preload_value <= `PRELOAD_RESET;
    else if (wr_start && hit_cfg && upper_half && run_en && !req.data[`TIMER_RUN_HALF_BIT])
      timer_preload_value <= `PRELOAD_RESET;
    else if (wr_start && hit_cfg && !upper_half)
      timer_preload_value <= req.data;
  end

  tick_divider #(
    .DIV(`TIMER_TICK_CYCLES)
  ) u_timer_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(timer_tick)
  );

  timer_core u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(timer_tick),
    .run(run_en),
    .preload(timer_preload_value),
    .count(timer_current_count),
    .expire(timer_expire)
  );

  // Event pulse for the interrupt controller outside this block
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_irq_event <= 1'b0;
    else
      timer_irq_event <= timer_expire;
  end

  logic free_tick;
  logic [31:0] free_cycle_count;

  tick_divider #(
    .DIV(`FREE_TICK_CYCLES)
  ) u_free_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(free_tick)
  );

  // No power-state input gates this counter: it runs in every state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      free_cycle_count <= `FREE_RESET;
    else if (free_tick)
      free_cycle_count <= free_cycle_count + 32'h0000_0001;
  end

  // Half-word coherence: capture on first half, serve the other half from capture
  logic [31:0] free_capture;
  logic capture_valid;
  logic capture_half;
  logic from_capture;

  assign from_capture = capture_valid && (capture_half != upper_half);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      free_capture <= 32'h0000_0000;
      capture_valid <= 1'b0;
      capture_half <= 1'b0;
    end
    else if (rd_start && hit_free)
    begin
      if (from_capture)
        capture_valid <= 1'b0;
      else
      begin
        free_capture <= free_cycle_count;
        capture_valid <= 1'b1;
        capture_half <= upper_half;
      end
    end
  end

  logic [31:0] read_word;
  logic [31:0] free_word;

  assign free_word = from_capture ? free_capture : free_cycle_count;

  always_comb
  begin
    read_word = 32'h0000_0000;
    if (hit_cfg)
      read_word = {2'b00, run_en, 13'h0000, timer_preload_value};
    else if (hit_cnt)
      read_word = {16'h0000, timer_current_count};
    else if (hit_free)
      read_word = free_word;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
    end
    else
    begin
      host_data_oe <= req.sel && req.rd;
      if (rd_start)
        host_data_out <= upper_half ? read_word[31:16] : read_word[15:0];
    end
  end

  // Checks on behaviour
  int unsigned since_reset;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      since_reset <= 0;
    else if (since_reset < 1000)
      since_reset <= since_reset + 1;
  end

  property p_run_set;
    @(posedge clk) disable iff (!rst_n)
    (wr_start && hit_cfg && upper_half) |=> (run_en == $past(req.data[13]));
  endproperty
  a_run_set: assert property (p_run_set) else $error("run bit not taken from write");

  property p_preload_preset;
    @(posedge clk) disable iff (!rst_n)
    $fell(run_en) |-> (timer_preload_value == 16'hFFFF);
  endproperty
  a_preload_preset: assert property (p_preload_preset) else $error("preload not preset on halt");

  property p_start_from_preload;
    @(posedge clk) disable iff (!rst_n)
    $rose(run_en) |=> (timer_current_count == $past(timer_preload_value));
  endproperty
  a_start_from_preload: assert property (p_start_from_preload) else $error("start value wrong");

  property p_count_read;
    @(posedge clk) disable iff (!rst_n)
    (rd_start && hit_cnt && !upper_half) |=> (host_data_out == $past(timer_current_count));
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read mismatch");

  property p_expire_event;
    @(posedge clk) disable iff (!rst_n)
    timer_expire |=> timer_irq_event ##1 !timer_irq_event;
  endproperty
  a_expire_event: assert property (p_expire_event) else $error("event pulse wrong");

  property p_free_step;
    @(posedge clk) disable iff (!rst_n)
    free_tick |=> (free_cycle_count == $past(free_cycle_count) + 32'h1) ##0 !free_tick[*3];
  endproperty
  a_free_step: assert property (p_free_step) else $error("free counter step wrong");

  property p_free_wrap;
    @(posedge clk) disable iff (!rst_n)
    (free_tick && free_cycle_count == 32'hFFFF_FFFF) |=> (free_cycle_count == 32'h0);
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free counter did not wrap");

  property p_coherent_half;
    @(posedge clk) disable iff (!rst_n)
    (rd_start && hit_free && from_capture)
      |=> (host_data_out == ($past(capture_half) ? $past(free_capture[15:0])
                                                  : $past(free_capture[31:16])));
  endproperty
  a_coherent_half: assert property (p_coherent_half) else $error("second half not coherent");

  property p_clear_time;
    @(posedge clk) disable iff (!rst_n)
    (since_reset < 16) |-> (free_cycle_count < 32'h10);
  endproperty
  a_clear_time: assert property (p_clear_time) else $error("counter not cleared in time");

  property p_never_stops;
    @(posedge clk) disable iff (!rst_n)
    (since_reset > 8) |-> ##[0:4] free_tick;
  endproperty
  a_never_stops: assert property (p_never_stops) else $error("free counter stalled");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
    timer_expire |-> (timer_current_count == $past(timer_preload_value));
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  property p_preload_isolated;
    @(posedge clk) disable iff (!rst_n)
    (run_en && $past(run_en) && $past(run_en, 2) && !$past(timer_tick) && !$rose(run_en))
      |-> $stable(timer_current_count);
  endproperty
  a_preload_isolated: assert property (p_preload_isolated) else $error("count moved off tick");

endmodule : host_timer_and_cycle_counter

// ===== verif/host_cpu_model.sv
// Host CPU model that drives the 16-bit SRAM-like bus of the timer block
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic clk,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [7:1] host_addr,
  output logic [15:0] host_data_in,
  input wire logic [15:0] host_data_out
);
  initial
  begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 7'h00;
    host_data_in = 16'h0000;
  end

  // One access: strobes held two edges, read data taken before release
  task automatic access(input logic [7:0] ofs, input logic wr, input logic [15:0] wdata,
      output logic [15:0] rdata);
    @(negedge clk);
    host_cs_n = 1'b0;
    host_rd_n = wr;
    host_wr_n = ~wr;
    host_addr = ofs[7:1];
    host_data_in = wdata;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    rdata = host_data_out;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    // Released lines show junk so nothing leans on the last value
    host_addr = ~host_addr;
    host_data_in = ~host_data_in;
  endtask : access
endmodule : host_cpu_model

// ===== verif/test_host_timer_and_cycle_counter.sv
// Testbench for the host timer and free-running cycle counter
`timescale 1ns/1ps
`include "host_timer_params.svh"
module test_host_timer_and_cycle_counter;
  logic clk;
  logic rstn;
  logic host_cs_n;
  logic host_rd_n;
  logic host_wr_n;
  logic [7:1] host_addr;
  logic [15:0] host_data_in;
  logic [15:0] host_data_out;
  logic host_data_oe;
  logic timer_irq_event;
  int n_errors;
  int num_checks;
  time irq_t[$];
  logic [15:0] d;
  logic [15:0] l0;
  logic [15:0] lc;
  int n;

  host_timer_and_cycle_counter dut (.clk(clk), .rstn(rstn), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .timer_irq_event(timer_irq_event));

  host_cpu_model host (.clk(clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk)
    if (timer_irq_event === 1'b1)
      irq_t.push_back($time);

  task automatic rd(input logic [7:0] ofs, output logic [15:0] v);
    host.access(ofs, 1'b0, 16'h0000, v);
  endtask : rd

  task automatic wr(input logic [7:0] ofs, input logic [15:0] v);
    logic [15:0] x;
    host.access(ofs, 1'b1, v, x);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    num_checks++;
    if (!(got >= lo && got <= hi))
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wait_irq(input int cnt);
    int k;
    for (k = 0; k < 3000 && irq_t.size() < cnt; k++)
      @(negedge clk);
    chk(irq_t.size() >= cnt, 1'b1);
  endtask : wait_irq

  function automatic logic [31:0] gap(input int i);
    return 32'((irq_t[i] - irq_t[i - 1]) / `CLK_PERIOD_NS);
  endfunction : gap

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end

  initial
  begin
    n_errors = 0;
    num_checks = 0;
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    // Host waits out the clearing time before trusting the counter
    repeat (`FREE_CLEAR_CYCLES) @(negedge clk);
    rd(`FREE_CYCLE_COUNTER_OFS, d);
    chk_rng(d, 0, 16'h0010);
    rd(`FREE_CYCLE_COUNTER_OFS + 8'h02, d);
    chk(d, 16'h0000);
    rd(`TIMER_CONFIG_OFS, d);
    chk(d, `PRELOAD_RESET);
    rd(`TIMER_CONFIG_OFS + 8'h02, d);
    chk(d, 16'h0000);
    rd(`TIMER_COUNT_OFS, d);
    chk(d, `COUNT_RESET);
    // Output enable stands while the read strobe is seen, drops a cycle after release
    chk(host_data_oe, 1'b1);
    @(negedge clk);
    chk(host_data_oe, 1'b0);
    wr(`TIMER_COUNT_OFS, 16'h1234);
    rd(`TIMER_COUNT_OFS, d);
    chk(d, `COUNT_RESET);
    rd(8'hA0, d);
    chk(d, 16'h0000);
    // Lower read captures; the upper half then comes from that capture
    rd(`FREE_CYCLE_COUNTER_OFS, l0);
    rd(`FREE_CYCLE_COUNTER_OFS + 8'h02, d);
    chk(d, 16'h0000);
    // Upper read again recaptures; the lower half after the wait is that capture
    rd(`FREE_CYCLE_COUNTER_OFS + 8'h02, d);
    chk(d, 16'h0000);
    repeat (1000) @(negedge clk);
    rd(`FREE_CYCLE_COUNTER_OFS, lc);
    chk_rng(lc - l0, 1, 8);
    rd(`FREE_CYCLE_COUNTER_OFS, d);
    chk_rng(d - lc, 250, 254);
    wr(`TIMER_CONFIG_OFS, 16'h0003);
    wr(`TIMER_CONFIG_OFS + 8'h02, 16'h2000);
    rd(`TIMER_CONFIG_OFS + 8'h02, d);
    chk(d, 16'h2000);
    rd(`TIMER_CONFIG_OFS, d);
    chk(d, 16'h0003);
    wait_irq(2);
    chk(gap(1), 4 * `TIMER_TICK_CYCLES);
    // New preload lands only at the following reload
    wr(`TIMER_CONFIG_OFS, 16'h0001);
    wait_irq(4);
    chk(gap(2), 4 * `TIMER_TICK_CYCLES);
    chk(gap(3), 2 * `TIMER_TICK_CYCLES);
    wr(`TIMER_CONFIG_OFS + 8'h02, 16'h0000);
    rd(`TIMER_CONFIG_OFS, d);
    chk(d, 16'hFFFF);
    rd(`TIMER_CONFIG_OFS + 8'h02, d);
    chk(d, 16'h0000);
    n = irq_t.size();
    rd(`TIMER_COUNT_OFS, l0);
    repeat (500) @(negedge clk);
    rd(`TIMER_COUNT_OFS, d);
    chk(d, l0);
    chk(irq_t.size(), n);
    close_out();
  end
endmodule : test_host_timer_and_cycle_counter
